// >>> design/nvac_top.sv
// What this block does
// [R1] 32 bytes, one byte per access
// [R2] five address bits, upper three read zero
// [R3] control at 40h bank one, indirect
// [R4] no write while program_permit is zero
// [R5] program_strobe starts write only if permitted
// [R6] fetch_strobe ignored while fetch_permit zero
// [R7] fetch reads byte, strobe clears when done
// [R8] data register holds until next operation
// [R9] software never sets both strobes together
// [R10] software sets permit then strobe next
// [R11] software masks interrupts around write start
// [R12] write timed by asynchronous slow timer
// [R13] software waits for stable slow clock
// [R14] software leaves control alone while writing
// [R15] reset clears permits and bank select
// [R16] write end sets done flag, interrupt
// [R17] software reloads address before every read
// [R18] software avoids sleep during operations
// [R19] bank_select_bit picks bank for indirect
// [R20] read finishes in fixed clock count
`timescale 1ns/1ps
`include "nvac_map.svh"

module nvac_top #(
   parameter int WRITE_TICKS = `NVAC_WRITE_TICKS
)(
   // clock and reset
   input  wire logic       CLK_IN,
   input  wire logic       RST_N_IN,
   input  wire logic       CE_IN,
   // core data memory access
   input  wire logic [7:0] ADDR_IN,
   input  wire logic       INDIRECT_IN,
   input  wire logic       WR_IN,
   input  wire logic       RD_IN,
   input  wire logic [7:0] WDATA_IN,
   output logic      [7:0] RDATA_OUT,
   // slow subsidiary clock
   input  wire logic       SUB_CLK_IN,
   // interrupt
   input  wire logic       DONE_IRQ_EN_IN,
   input  wire logic       GLOBAL_IRQ_EN_IN,
   input  wire logic       IRQ_ACK_IN,
   output logic            IRQ_REQ_OUT
);

   localparam int AW = `NVAC_ADDR_BITS;

   nvac_pkg::nvac_state_type state;
   nvac_pkg::nvac_state_type next_state;

   logic [AW-1:0] nv_address;
   logic [7:0]    nv_data;
   logic [3:0]    nv_control;
   logic          bank_select;
   logic          nv_done_flag;
   logic [AW-1:0] prog_addr;
   logic [7:0]    prog_data;
   logic [7:0]    store_rdata;
   logic          prog_done;

   // register hit: direct access always bank 0, indirect follows bank_select
   function automatic logic reg_hit(input logic [7:0] addr, input logic ind,
                                    input logic bank, input logic [7:0] ofs,
                                    input logic want_bank);
      logic eff_bank;
      eff_bank = ind ? bank : 1'b0;
      reg_hit  = (addr == ofs) && (eff_bank == want_bank);
   endfunction

   wire eff_bank_one = INDIRECT_IN & bank_select; // R19
   wire hit_addr = reg_hit(ADDR_IN, INDIRECT_IN, bank_select, `NVAC_ADDR_OFS, 1'b0);
   wire hit_data = reg_hit(ADDR_IN, INDIRECT_IN, bank_select, `NVAC_DATA_OFS, 1'b0);
   wire hit_bank = reg_hit(ADDR_IN, INDIRECT_IN, bank_select, `NVAC_BANK_OFS, 1'b0);
   wire hit_ctrl = reg_hit(ADDR_IN, INDIRECT_IN, bank_select, `NVAC_CTRL_OFS, 1'b1); // R3

   wire addr_wr = WR_IN & hit_addr;
   wire data_wr = WR_IN & hit_data;
   wire bank_wr = WR_IN & hit_bank;
   wire ctrl_wr = WR_IN & hit_ctrl;

   wire idle      = (state == nvac_pkg::NVAC_IDLE);
   // control writes are ignored while an operation runs
   wire ctrl_ok   = ctrl_wr & idle;
   wire prog_perm = nv_control[`NVAC_PROG_PERMIT];
   wire fetch_perm = nv_control[`NVAC_FETCH_PERMIT];
   wire prog_go   = ctrl_ok & WDATA_IN[`NVAC_PROG_STROBE] & prog_perm; // R5
   wire fetch_go  = ctrl_ok & WDATA_IN[`NVAC_FETCH_STROBE] & fetch_perm & !prog_go; // R6
   wire read_end  = (state == nvac_pkg::NVAC_RD_DATA);
   wire write_end = (state == nvac_pkg::NVAC_WRITE) & prog_done;
   wire store_we  = write_end & prog_perm; // R4
   wire store_re  = (state == nvac_pkg::NVAC_RD_ADDR);

   // control next value: permits from software, strobes owned by hardware
   wire [3:0] next_nv_control;
   assign next_nv_control[`NVAC_PROG_PERMIT]  =
      ctrl_ok ? WDATA_IN[`NVAC_PROG_PERMIT] : prog_perm;
   assign next_nv_control[`NVAC_FETCH_PERMIT] =
      ctrl_ok ? WDATA_IN[`NVAC_FETCH_PERMIT] : fetch_perm;
   assign next_nv_control[`NVAC_PROG_STROBE]  =
      prog_go | (nv_control[`NVAC_PROG_STROBE] & !write_end); // R5
   assign next_nv_control[`NVAC_FETCH_STROBE] =
      fetch_go | (nv_control[`NVAC_FETCH_STROBE] & !read_end); // R7

   // done flag: a new event wins over service
   wire next_nv_done_flag = write_end | (nv_done_flag & !IRQ_ACK_IN); // R16
   wire next_irq = next_nv_done_flag & DONE_IRQ_EN_IN & GLOBAL_IRQ_EN_IN; // R16

   // read-back selection
   wire [7:0] rd_mux =
      hit_addr ? {{(8-AW){1'b0}}, nv_address} : // R2
      hit_data ? nv_data :
      hit_bank ? {7'h00, bank_select} :
      hit_ctrl ? {4'h0, nv_control} :
      8'h00;

   // data register: read result, else software write
   wire [7:0] next_nv_data = read_end ? store_rdata : (data_wr ? WDATA_IN : nv_data); // R8

   always_comb
   begin
      next_state = state;
      case (state)
         nvac_pkg::NVAC_IDLE:
         begin
            if (prog_go)
            begin
               next_state = nvac_pkg::NVAC_WRITE;
            end
            else if (fetch_go)
            begin
               next_state = nvac_pkg::NVAC_RD_ADDR;
            end
         end
         nvac_pkg::NVAC_RD_ADDR: next_state = nvac_pkg::NVAC_RD_DATA; // R20
         nvac_pkg::NVAC_RD_DATA: next_state = nvac_pkg::NVAC_IDLE;
         nvac_pkg::NVAC_WRITE:
         begin
            if (prog_done)
            begin
               next_state = nvac_pkg::NVAC_IDLE; // R12
            end
         end
         default: next_state = nvac_pkg::NVAC_IDLE;
      endcase
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         state        <= nvac_pkg::NVAC_IDLE;
         nv_control   <= `NVAC_CTRL_RST; // R15
         bank_select  <= `NVAC_BANK_RST; // R15
         nv_address   <= `NVAC_ADDR_RST;
         nv_data      <= `NVAC_DATA_RST;
         nv_done_flag <= 1'b0;
         IRQ_REQ_OUT  <= 1'b0;
         RDATA_OUT    <= 8'h00;
      end
      else if (CE_IN)
      begin
         state        <= next_state;
         nv_control   <= next_nv_control;
         nv_data      <= next_nv_data;
         nv_done_flag <= next_nv_done_flag;
         IRQ_REQ_OUT  <= next_irq;
         bank_select  <= bank_wr ? WDATA_IN[0] : bank_select; // R19
         nv_address   <= addr_wr ? WDATA_IN[AW-1:0] : nv_address; // R2
         RDATA_OUT    <= RD_IN ? rd_mux : RDATA_OUT;
      end
   end

   // write operands are captured when the cycle starts
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         prog_addr <= `NVAC_ADDR_RST;
         prog_data <= `NVAC_DATA_RST;
      end
      else if (CE_IN && prog_go)
      begin
         prog_addr <= nv_address;
         prog_data <= nv_data;
      end
   end

   nvac_store #(
      .AW    (AW),
      .DEPTH (`NVAC_DEPTH)
   ) u_store (
      .clk_in    (CLK_IN),
      .rst_n_in  (RST_N_IN),
      .ce_in     (CE_IN),
      .we_in     (store_we), // R1
      .waddr_in  (prog_addr),
      .wdata_in  (prog_data),
      .re_in     (store_re),
      .raddr_in  (nv_address),
      .rdata_out (store_rdata)
   );

   nvac_write_timer #(
      .TICKS (WRITE_TICKS)
   ) u_timer (
      .clk_in     (CLK_IN),
      .rst_n_in   (RST_N_IN),
      .ce_in      (CE_IN),
      .sub_clk_in (SUB_CLK_IN),
      .start_in   (prog_go), // R12
      .done_out   (prog_done)
   );

   // checks, valid while the clock enable is high

   sequence s_fetch_start;
      $rose(nv_control[`NVAC_FETCH_STROBE]);
   endsequence

   sequence s_fetch_hold;
      nv_control[`NVAC_FETCH_STROBE] [*2] ##1 !nv_control[`NVAC_FETCH_STROBE];
   endsequence

   property p_addr_upper_zero;
      @(posedge CLK_IN) disable iff (!RST_N_IN || !CE_IN)
      (RD_IN && hit_addr) |=> (RDATA_OUT[7:5] == 3'h0);
   endproperty
   a_addr_upper_zero: assert property (p_addr_upper_zero) // R2
      else $error("address read-back upper bits not zero");

   property p_ctrl_bank_one;
      @(posedge CLK_IN) disable iff (!RST_N_IN || !CE_IN)
      (WR_IN && !eff_bank_one) |=>
         ($stable(nv_control[`NVAC_PROG_PERMIT]) && $stable(nv_control[`NVAC_FETCH_PERMIT]));
   endproperty
   a_ctrl_bank_one: assert property (p_ctrl_bank_one) // R3
      else $error("control reached outside indirect bank one");

   property p_store_needs_permit;
      @(posedge CLK_IN) disable iff (!RST_N_IN || !CE_IN)
      store_we |-> nv_control[`NVAC_PROG_PERMIT];
   endproperty
   a_store_needs_permit: assert property (p_store_needs_permit) // R4
      else $error("store written without program permit");

   property p_prog_needs_permit;
      @(posedge CLK_IN) disable iff (!RST_N_IN || !CE_IN)
      $rose(nv_control[`NVAC_PROG_STROBE]) |-> $past(nv_control[`NVAC_PROG_PERMIT]);
   endproperty
   a_prog_needs_permit: assert property (p_prog_needs_permit) // R5
      else $error("write started without prior permit");

   property p_fetch_needs_permit;
      @(posedge CLK_IN) disable iff (!RST_N_IN || !CE_IN)
      s_fetch_start |-> $past(nv_control[`NVAC_FETCH_PERMIT]);
   endproperty
   a_fetch_needs_permit: assert property (p_fetch_needs_permit) // R6
      else $error("read started without prior permit");

   property p_fetch_data;
      @(posedge CLK_IN) disable iff (!RST_N_IN || !CE_IN)
      $fell(nv_control[`NVAC_FETCH_STROBE]) |-> (nv_data == store_rdata);
   endproperty
   a_fetch_data: assert property (p_fetch_data) // R7
      else $error("data register not loaded at read end");

   property p_data_holds;
      @(posedge CLK_IN) disable iff (!RST_N_IN || !CE_IN)
      (idle && !data_wr) |=> $stable(nv_data);
   endproperty
   a_data_holds: assert property (p_data_holds) // R8
      else $error("data register changed without operation");

   property p_prog_holds;
      @(posedge CLK_IN) disable iff (!RST_N_IN || !CE_IN)
      (nv_control[`NVAC_PROG_STROBE] && !prog_done) |=> nv_control[`NVAC_PROG_STROBE];
   endproperty
   a_prog_holds: assert property (p_prog_holds) // R12
      else $error("write strobe cleared before timer end");

   property p_done_flag;
      @(posedge CLK_IN) disable iff (!RST_N_IN || !CE_IN)
      write_end |=> (nv_done_flag && !nv_control[`NVAC_PROG_STROBE]);
   endproperty
   a_done_flag: assert property (p_done_flag) // R16
      else $error("done flag not set at write end");

   property p_fetch_time;
      @(posedge CLK_IN) disable iff (!RST_N_IN || !CE_IN)
      s_fetch_start |-> s_fetch_hold;
   endproperty
   a_fetch_time: assert property (p_fetch_time) // R20
      else $error("read strobe not held two cycles then cleared");

   property p_irq_follows_flag;
      @(posedge CLK_IN) disable iff (!RST_N_IN || !CE_IN)
      (nv_done_flag && !IRQ_ACK_IN && DONE_IRQ_EN_IN && GLOBAL_IRQ_EN_IN) |=> IRQ_REQ_OUT;
   endproperty
   a_irq_follows_flag: assert property (p_irq_follows_flag) // R16
      else $error("interrupt request missing while flag set");

   property p_ack_clears;
      @(posedge CLK_IN) disable iff (!RST_N_IN || !CE_IN)
      (IRQ_ACK_IN && !write_end) |=> (!nv_done_flag && !IRQ_REQ_OUT);
   endproperty
   a_ack_clears: assert property (p_ack_clears) // R16
      else $error("done flag not cleared by service");

endmodule

// >>> design/nvac_map.svh
`ifndef NVAC_MAP_SVH
`define NVAC_MAP_SVH

// direct (bank 0) locations of the address, data and bank registers
`define NVAC_ADDR_OFS      8'h1e
`define NVAC_DATA_OFS      8'h1f
`define NVAC_BANK_OFS      8'h04
// control register, bank 1, indirect access only
`define NVAC_CTRL_OFS      8'h40

// control field positions
`define NVAC_FETCH_STROBE  0
`define NVAC_FETCH_PERMIT  1
`define NVAC_PROG_STROBE   2
`define NVAC_PROG_PERMIT   3

// field widths and reset values
`define NVAC_ADDR_BITS     5
`define NVAC_DEPTH         32
`define NVAC_ADDR_RST      5'h00
`define NVAC_DATA_RST      8'h00
`define NVAC_CTRL_RST      4'h0
`define NVAC_BANK_RST      1'b0

// slow clock ticks per write cycle
`define NVAC_WRITE_TICKS   8

`endif

// >>> design/nvac_pkg.sv
package nvac_pkg;

   typedef enum logic [1:0]
   {
      NVAC_IDLE    = 2'b00,
      NVAC_RD_ADDR = 2'b01,
      NVAC_RD_DATA = 2'b10,
      NVAC_WRITE   = 2'b11
   } nvac_state_type;

endpackage

// >>> design/nvac_store.sv
`timescale 1ns/1ps

module nvac_store #(
   parameter int AW    = 5,
   parameter int DEPTH = 32
)(
   // clock
   input  wire logic          clk_in,
   input  wire logic          rst_n_in,
   input  wire logic          ce_in,
   // write port
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [7:0]    wdata_in,
   // read port
   input  wire logic          re_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic      [7:0]    rdata_out
);

   logic [7:0] cells [DEPTH];

   always_ff @(posedge clk_in)
   begin
      if (ce_in && we_in)
      begin
         cells[waddr_in] <= wdata_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rdata_out <= 8'h00;
      end
      else if (ce_in && re_in)
      begin
         rdata_out <= cells[raddr_in];
      end
   end

endmodule

// >>> design/nvac_write_timer.sv
`timescale 1ns/1ps

module nvac_write_timer #(
   parameter int TICKS = 8
)(
   // clock
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic ce_in,
   // slow clock pin
   input  wire logic sub_clk_in,
   // control
   input  wire logic start_in,
   output logic      done_out
);

   localparam int CW = $clog2(TICKS + 1);

   logic [2:0]    sync;
   logic          level;
   logic [CW-1:0] count;
   logic          running;

   // filtered slow clock: a rise counts once stages two and three agree
   wire agree   = (sync[1] == sync[2]);
   wire tick    = agree && sync[2] && !level;
   wire last    = running && tick && (count == CW'(TICKS - 1));

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sync     <= 3'h0;
         level    <= 1'b0;
         count    <= '0;
         running  <= 1'b0;
         done_out <= 1'b0;
      end
      else if (ce_in)
      begin
         sync     <= {sync[1:0], sub_clk_in};
         level    <= agree ? sync[2] : level;
         done_out <= last;
         if (start_in)
         begin
            running <= 1'b1;
            count   <= '0;
         end
         else if (last)
         begin
            running <= 1'b0;
         end
         else if (running && tick)
         begin
            count <= count + CW'(1);
         end
      end
   end

endmodule

// >>> test/nvac_top_tb.sv
`timescale 1ns/1ps
`include "nvac_map.svh"

module nvac_top_tb;
   typedef struct packed
   {
      logic [7:0] ofs;
      int         ind;
      logic [7:0] wd;
      logic [7:0] ex;
   } nvac_row_type;

   logic       clk;
   logic       rst_n;
   logic       ce;
   logic [7:0] addr;
   logic       ind;
   logic       wr;
   logic       rd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       sub_clk;
   logic       dn_en;
   logic       gl_en;
   logic       ack;
   logic       irq;
   int         fails;
   int         checked;
   int         n;
   nvac_row_type rows [7];

   nvac_top #(.WRITE_TICKS(2)) dut_u (
      .CLK_IN           (clk),
      .RST_N_IN         (rst_n),
      .CE_IN            (ce),
      .ADDR_IN          (addr),
      .INDIRECT_IN      (ind),
      .WR_IN            (wr),
      .RD_IN            (rd),
      .WDATA_IN         (wdata),
      .RDATA_OUT        (rdata),
      .SUB_CLK_IN       (sub_clk),
      .DONE_IRQ_EN_IN   (dn_en),
      .GLOBAL_IRQ_EN_IN (gl_en),
      .IRQ_ACK_IN       (ack),
      .IRQ_REQ_OUT      (irq)
   );

   // clocks; slow clock unrelated in phase
   always #5 clk = ~clk;
   always #37.3 sub_clk = ~sub_clk;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("counts: %0d checked, %0d failed", checked, fails);
      if (fails == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one access; strobe stays up for back-to-back use
   task automatic acc(input logic w, input logic [7:0] o, input int i, input logic [7:0] d);
      wr = w;
      rd = !w;
      addr = o;
      ind = i[0];
      wdata = d;
      @(posedge clk);
      #1;
   endtask

   task automatic idle();
      wr = 1'b0;
      rd = 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic rdc(input logic [7:0] o, input int i, input logic [7:0] exp);
      acc(1'b0, o, i, 8'h00);
      chk(rdata, exp);
   endtask

   task automatic wc(input logic [7:0] d);
      acc(1'b1, `NVAC_CTRL_OFS, 1, d);
   endtask

   // poll control until the masked bits clear
   task automatic poll(input logic [7:0] m, output int cnt);
      cnt = 0;
      do
      begin
         acc(1'b0, `NVAC_CTRL_OFS, 1, 8'h00);
         cnt++;
      end
      while ((rdata & m) !== 8'h00 && cnt < 300);
      idle();
   endtask

   initial
   begin
      #300000;
      fails++;
      tally_and_finish();
   end

   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      addr = 8'h00;
      ind = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
      sub_clk = 1'b0;
      dn_en = 1'b0;
      gl_en = 1'b0;
      ack = 1'b0;
      fails = 0;
      checked = 0;
      rows = '{'{`NVAC_ADDR_OFS, 0, 8'hff, 8'h1f}, '{`NVAC_ADDR_OFS, 0, 8'h0a, 8'h0a},
               '{`NVAC_DATA_OFS, 0, 8'ha5, 8'ha5}, '{`NVAC_BANK_OFS, 0, 8'hff, 8'h01},
               '{`NVAC_BANK_OFS, 0, 8'h00, 8'h00}, '{8'h10, 0, 8'h77, 8'h00},
               '{`NVAC_CTRL_OFS, 0, 8'h0a, 8'h00}};
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1;
      chk(rdata, 8'h00);
      chk({7'h00, irq}, 8'h00);
      rdc(`NVAC_ADDR_OFS, 0, 8'h00);
      rdc(`NVAC_DATA_OFS, 0, 8'h00);
      rdc(`NVAC_BANK_OFS, 0, 8'h00);
      acc(1'b1, `NVAC_BANK_OFS, 0, 8'h01);
      rdc(`NVAC_CTRL_OFS, 1, 8'h00);
      idle();
      $display("test reset values done");
      foreach (rows[k])
      begin
         acc(1'b1, rows[k].ofs, rows[k].ind, rows[k].wd);
         rdc(rows[k].ofs, rows[k].ind, rows[k].ex);
      end
      idle();
      $display("test register rows done");
      // indirect 40h in bank zero is not the control register
      acc(1'b1, `NVAC_CTRL_OFS, 1, 8'h02);
      acc(1'b1, `NVAC_BANK_OFS, 0, 8'h01);
      rdc(`NVAC_CTRL_OFS, 1, 8'h00);
      idle();
      $display("test bank decode done");
      // write cycle with interrupt
      dn_en = 1'b1;
      acc(1'b1, `NVAC_ADDR_OFS, 0, 8'h05);
      acc(1'b1, `NVAC_DATA_OFS, 0, 8'h3c);
      wc(8'h08);
      wc(8'h0c);
      gl_en = 1'b1;
      rdc(`NVAC_CTRL_OFS, 1, 8'h0c);
      poll(8'h04, n);
      chk({7'h00, n < 300}, 8'h01);
      chk({7'h00, n > 2}, 8'h01);
      chk({7'h00, irq}, 8'h01);
      ack = 1;
      @(posedge clk);
      #1;
      ack = 0;
      @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h00);
      $display("test write cycle done");
      // read back
      acc(1'b1, `NVAC_ADDR_OFS, 0, 8'h05);
      wc(8'h02);
      wc(8'h03);
      poll(8'h01, n);
      chk({7'h00, n <= 3}, 8'h01);
      rdc(`NVAC_DATA_OFS, 0, 8'h3c);
      rdc(`NVAC_CTRL_OFS, 1, 8'h02);
      rdc(`NVAC_DATA_OFS, 0, 8'h3c);
      idle();
      $display("test read cycle done");
      // strobe without permit
      wc(8'h00);
      acc(1'b1, `NVAC_DATA_OFS, 0, 8'h99);
      wc(8'h04);
      rdc(`NVAC_CTRL_OFS, 1, 8'h00);
      idle();
      repeat (60) @(posedge clk);
      #1;
      acc(1'b1, `NVAC_ADDR_OFS, 0, 8'h05);
      wc(8'h02);
      wc(8'h03);
      poll(8'h01, n);
      rdc(`NVAC_DATA_OFS, 0, 8'h3c);
      wc(8'h00);
      acc(1'b1, `NVAC_DATA_OFS, 0, 8'h55);
      wc(8'h01);
      rdc(`NVAC_CTRL_OFS, 1, 8'h00);
      rdc(`NVAC_DATA_OFS, 0, 8'h55);
      idle();
      $display("test refused strobes done");
      // second reset in mid-run
      wc(8'h08);
      idle();
      rst_n = 0;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1;
      rdc(`NVAC_BANK_OFS, 0, 8'h00);
      acc(1'b1, `NVAC_BANK_OFS, 0, 8'h01);
      rdc(`NVAC_CTRL_OFS, 1, 8'h00);
      idle();
      $display("test second reset done");
      // clock enable low freezes registers and read data
      ce = 1'b0;
      acc(1'b1, `NVAC_BANK_OFS, 0, 8'h00);
      rdc(`NVAC_BANK_OFS, 0, 8'h00);
      ce = 1'b1;
      rdc(`NVAC_BANK_OFS, 0, 8'h01);
      idle();
      $display("test clock enable done");
      tally_and_finish();
   end
endmodule
